// file: hdl/ssm_i2c_defs.vh
// Constants for the two-wire byte framing engine
// Assumes a 100 MHz system clock
`ifndef SSM_I2C_DEFS_VH
`define SSM_I2C_DEFS_VH
`define SSM_CLK_MHZ 100
`define SSM_HOLD_LONG_NS 300
`define SSM_HOLD_LONG_CYC ((`SSM_HOLD_LONG_NS * `SSM_CLK_MHZ + 999) / 1000)
`define SSM_HOLD_SHORT_CYC 8'h01
`define SSM_BITS_PER_BYTE 4'h8
`define SSM_ACK_SLOT 4'h8
`define SSM_ADDR_W 7
`define SSM_ST_IDLE 3'h0
`define SSM_ST_ADDR 3'h1
`define SSM_ST_ADDR_ACK 3'h2
`define SSM_ST_RX 3'h3
`define SSM_ST_RX_ACK 3'h4
`define SSM_ST_TX 3'h5
`define SSM_ST_TX_ACK 3'h6
`define SSM_ST_WAIT 3'h7
`endif

// file: hdl/ssm_i2c_slave.v
// Two-wire bus slave framing engine: byte shifting, acknowledge, conditions
// Assumes external pull-ups; pins resolved outside from the output enables
//
// Function
// - Bytes move whole, most significant bit first.
// - Each unit is eight data bits then one acknowledge bit.
// - Data sender releases line after eighth fall, samples acknowledge.
// - Only a master generates clock; this slave never makes pulses.
// - Data changes while clock low; sampling on clock rise.
// - Data change during clock high is start or stop.
// - Enabled, both pins act as open-drain outputs.
// - Pin output value fixed at zero; only pull low or release.
// - Long hold select keeps data 300 ns after clock fall.
// - Bus idle when no master active and both lines high.
// - Address matches only if equal to slave address register.
// - Matching address with write bit clear starts receiving bytes.
// - Read request: slave supplies bytes until master not-acknowledge, restart or stop.
// - Collision when data sampled low while driving high.
// - Any party may hold clock low; others wait for release.
// - Arbitration keeps one master; winner message uncorrupted.
// - Clocks of several drivers follow the wired-AND level.
`timescale 1ns/1ns
`include "ssm_i2c_defs.vh"
module ssm_i2c_slave
#(
  parameter ADDR_W = `SSM_ADDR_W,
  parameter HOLD_LONG_CYC = `SSM_HOLD_LONG_CYC
)
(
  input wire clk,
  input wire sys_rst,
  input wire serial_port_enable_bit,
  input wire data_hold_long_select,
  input wire [ADDR_W-1:0] slave_address_register,
  input wire scl_i,
  output reg scl_o,
  output reg scl_oe,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe,
  input wire stretch_req,
  input wire [7:0] tx_data,
  output reg tx_take_q,
  output reg [7:0] rx_data_q,
  output reg rx_valid_q,
  output reg addr_match_q,
  output reg read_req_q,
  output reg bus_idle_q,
  output reg start_seen_q,
  output reg stop_seen_q,
  output reg collision_q,
  output reg nack_seen_q
);
  localparam HW = 8;
  wire scl_s;
  wire sda_s;
  reg scl_d1_q;
  reg sda_d1_q;
  reg [2:0] st_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg drive_low_q;
  reg pend_low_q;
  reg [HW-1:0] hold_q;
  reg active_q;
  reg master_ack_q;
  wire scl_rise;
  wire scl_fall;
  wire start_c;
  wire stop_c;
  wire [HW-1:0] hold_len;

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  // Real pin levels
  ssm_pin_sync u_scl_sync
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_i(scl_i),
    .level_q(scl_s)
  );
  ssm_pin_sync u_sda_sync
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_i(sda_i),
    .level_q(sda_s)
  );

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end
    else
    begin
      scl_d1_q <= scl_s;
      sda_d1_q <= sda_s;
    end
  end

  // Clock edges follow wired-AND pin level
  assign scl_rise = scl_s & ~scl_d1_q;
  assign scl_fall = ~scl_s & scl_d1_q;
  assign start_c = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
  assign stop_c = scl_s & scl_d1_q & ~sda_d1_q & sda_s;

  assign hold_len = data_hold_long_select ? HOLD_LONG_CYC[HW-1:0] :
    `SSM_HOLD_SHORT_CYC;

  // ----------------------------------------------------------------
  // Framing state machine
  // ----------------------------------------------------------------
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q <= `SSM_ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      drive_low_q <= 1'b0;
      pend_low_q <= 1'b0;
      hold_q <= {HW{1'b0}};
      active_q <= 1'b0;
      master_ack_q <= 1'b0;
      tx_take_q <= 1'b0;
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
      addr_match_q <= 1'b0;
      read_req_q <= 1'b0;
      start_seen_q <= 1'b0;
      stop_seen_q <= 1'b0;
      collision_q <= 1'b0;
      nack_seen_q <= 1'b0;
    end
    else
    begin
      tx_take_q <= 1'b0;
      rx_valid_q <= 1'b0;
      start_seen_q <= start_c;
      stop_seen_q <= stop_c;
      collision_q <= 1'b0;
      nack_seen_q <= 1'b0;
      // Data waits hold time after clock fall
      if (hold_q != {HW{1'b0}})
      begin
        hold_q <= hold_q - 1'b1;
        if (hold_q == {{(HW-1){1'b0}}, 1'b1})
          drive_low_q <= pend_low_q;
      end
      if (!serial_port_enable_bit)
      begin
        st_q <= `SSM_ST_IDLE;
        drive_low_q <= 1'b0;
        hold_q <= {HW{1'b0}};
        active_q <= 1'b0;
        addr_match_q <= 1'b0;
        read_req_q <= 1'b0;
      end
      else if (start_c)
      begin
        // Restart re-listens, so only the winning master's bytes count
        st_q <= `SSM_ST_ADDR;
        bit_q <= 4'h0;
        active_q <= 1'b1;
        drive_low_q <= 1'b0;
        hold_q <= {HW{1'b0}};
        addr_match_q <= 1'b0;
        read_req_q <= 1'b0;
      end
      else if (stop_c)
      begin
        // Stop ends any read or write
        st_q <= `SSM_ST_IDLE;
        active_q <= 1'b0;
        drive_low_q <= 1'b0;
        hold_q <= {HW{1'b0}};
        addr_match_q <= 1'b0;
        read_req_q <= 1'b0;
      end
      else
      begin
        // Driving high yet pin low on clock rise
        if (scl_rise && st_q == `SSM_ST_TX && !drive_low_q && !sda_s)
          collision_q <= 1'b1;
        case (st_q)
          `SSM_ST_ADDR, `SSM_ST_RX:
          begin
            if (scl_rise)
            begin
              // Shift in most significant bit first
              sh_q <= {sh_q[6:0], sda_s};
              bit_q <= bit_q + 4'h1;
            end
            if (scl_fall && bit_q == `SSM_BITS_PER_BYTE)
            begin
              if (st_q == `SSM_ST_ADDR)
              begin
                if (sh_q[7:1] == slave_address_register)
                begin
                  addr_match_q <= 1'b1;
                  read_req_q <= sh_q[0];
                  pend_low_q <= 1'b1;
                  hold_q <= hold_len;
                  st_q <= `SSM_ST_ADDR_ACK;
                end
                else
                  st_q <= `SSM_ST_WAIT;
              end
              else
              begin
                rx_data_q <= sh_q;
                rx_valid_q <= 1'b1;
                pend_low_q <= 1'b1;
                hold_q <= hold_len;
                st_q <= `SSM_ST_RX_ACK;
              end
            end
          end
          `SSM_ST_ADDR_ACK, `SSM_ST_RX_ACK:
          begin
            if (scl_fall)
            begin
              bit_q <= 4'h0;
              if (st_q == `SSM_ST_ADDR_ACK && read_req_q)
              begin
                sh_q <= tx_data;
                tx_take_q <= 1'b1;
                pend_low_q <= ~tx_data[7];
                hold_q <= hold_len;
                st_q <= `SSM_ST_TX;
              end
              else
              begin
                pend_low_q <= 1'b0;
                hold_q <= hold_len;
                st_q <= `SSM_ST_RX;
              end
            end
          end
          `SSM_ST_TX:
          begin
            if (scl_rise)
              bit_q <= bit_q + 4'h1;
            if (scl_fall)
            begin
              if (bit_q == `SSM_BITS_PER_BYTE)
              begin
                pend_low_q <= 1'b0;
                hold_q <= hold_len;
                st_q <= `SSM_ST_TX_ACK;
              end
              else
              begin
                sh_q <= {sh_q[6:0], 1'b0};
                pend_low_q <= ~sh_q[6];
                hold_q <= hold_len;
              end
            end
          end
          `SSM_ST_TX_ACK:
          begin
            if (scl_rise)
              master_ack_q <= ~sda_s;
            if (scl_fall)
            begin
              bit_q <= 4'h0;
              if (master_ack_q)
              begin
                sh_q <= tx_data;
                tx_take_q <= 1'b1;
                pend_low_q <= ~tx_data[7];
                hold_q <= hold_len;
                st_q <= `SSM_ST_TX;
              end
              else
              begin
                nack_seen_q <= 1'b1;
                st_q <= `SSM_ST_WAIT;
              end
            end
          end
          `SSM_ST_WAIT:
            st_q <= `SSM_ST_WAIT;
          default:
            st_q <= `SSM_ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Open-drain pin drive and bus state
  // ----------------------------------------------------------------
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
      scl_o <= 1'b0;
      scl_oe <= 1'b0;
      bus_idle_q <= 1'b0;
    end
    else
    begin
      sda_o <= 1'b0;
      scl_o <= 1'b0;
      sda_oe <= serial_port_enable_bit & drive_low_q;
      // Clock only held low, never pulsed; stretching
      scl_oe <= serial_port_enable_bit & stretch_req & addr_match_q & ~scl_s;
      // Idle: no master active, both lines high
      bus_idle_q <= ~active_q & scl_s & sda_s;
    end
  end
endmodule // ssm_i2c_slave

// file: hdl/ssm_pin_sync.v
// Three-stage synchroniser with agreement filter for one bus pin
// Assumes the input is asynchronous to clk
`timescale 1ns/1ns
module ssm_pin_sync
(
  input wire clk,
  input wire sys_rst,
  input wire pin_i,
  output reg level_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      level_q <= 1'b1;
    end
    else
    begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // A change counts once the last two stages agree
      if (s2_q == s3_q)
        level_q <= s3_q;
    end
  end
endmodule // ssm_pin_sync

// file: sim/i2c_bus_byte_framing_tb.sv
// Bench for the two-wire slave framing engine
// Master model on a wired-AND bus with pull-ups
`timescale 1ns/1ns
module i2c_bus_byte_framing_tb;
  logic clk, sys_rst, en, hl, str_req, a;
  logic [6:0] adr;
  logic [7:0] txd, q, d;
  wire scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda, tk, rxv, am, rr, idl, st, sp, col, nk;
  wire [7:0] rxd;
  int err_total, checks_done, cyc, n_st, n_col, n_str, n_nk, n_exp, n_sp, n_tk;
  logic [7:0] rxq[$];
  wire scl = (scl_oe ? scl_o : 1'b1) & !m_scl;
  wire sda = (sda_oe ? sda_o : 1'b1) & !m_sda;
  ssm_i2c_slave dut(.clk(clk), .sys_rst(sys_rst), .serial_port_enable_bit(en),
    .data_hold_long_select(hl), .slave_address_register(adr), .scl_i(scl),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .stretch_req(str_req), .tx_data(txd), .tx_take_q(tk), .rx_data_q(rxd),
    .rx_valid_q(rxv), .addr_match_q(am), .read_req_q(rr), .bus_idle_q(idl),
    .start_seen_q(st), .stop_seen_q(sp), .collision_q(col), .nack_seen_q(nk));
  ssm_i2c_master_model m(.scl(scl), .sda(sda), .scl_oe_m(m_scl), .sda_oe_m(m_sda));
  always #5 clk = !clk;
  always @(posedge clk)
  begin
    if (rxv)
      rxq.push_back(rxd);
    n_st += st;
    n_col += col;
    n_nk += nk;
    n_sp += sp;
    n_tk += tk;
    n_str += scl_oe;
    if (++cyc == 20000)
    begin
      err_total++;
      stop_test;
    end
  end
  function automatic logic ack_of(input logic [6:0] ad);
    return ad !== adr;
  endfunction
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task ap(input logic [6:0] ad, input logic rw);
    n_exp++;
    m.start;
    m.xfer({ad, rw}, 1'b1, q, a);
    chk("addr_ack", {7'h0, ack_of(ad)}, {7'h0, a});
  endtask
  initial
  begin
    clk = 0;
    sys_rst = 1;
    en = 1;
    hl = 0;
    str_req = 0;
    txd = 8'h00;
    adr = 7'($urandom(32'h3918));
    repeat (4) @(posedge clk);
    #1 sys_rst = 0;
    repeat (10) @(posedge clk);
    chk("idle", 8'h01, {7'h0, idl});
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      #1 hl = k[0];
      str_req = k[0];
      m.lo_ns = k ? 500 : 120;
      if (k)
        fork
          begin
            // Stretch only once addressed, then let the clock go
            @(posedge am);
            #3000;
            @(posedge clk);
            #1 str_req = 0;
          end
        join_none
      ap(adr, 1'b0);
      repeat (2)
      begin
        d = 8'($urandom);
        m.xfer(d, 1'b1, q, a);
        chk("data_ack", 8'h00, {7'h0, a});
        chk("rx_data", d, rxq.pop_front());
      end
      m.stop;
      $display("test %0d done", k + 1);
    end
    chk("stretched", 8'h01, {7'h0, n_str > 0});
    ap(adr ^ 7'h01, 1'b0);
    m.stop;
    chk("rx_none", 8'h00, 8'(rxq.size()));
    d = 8'($urandom);
    @(posedge clk);
    #1 txd = d;
    ap(adr, 1'b1);
    m.xfer(8'hFF, 1'b0, q, a);
    chk("tx_data", d, q);
    @(posedge clk);
    #1 txd = ~d;
    m.xfer(8'hFF, 1'b1, q, a);
    chk("tx_next", ~d, q);
    m.stop;
    chk("nack", 8'h01, 8'(n_nk));
    chk("no_coll", 8'h00, {7'h0, n_col > 0});
    $display("test 3 done");
    @(posedge clk);
    #1 txd = {1'b1, 7'($urandom)};
    ap(adr, 1'b1);
    m.xfer(8'h00, 1'b1, q, a);
    m.stop;
    chk("collision", 8'h01, {7'h0, n_col > 0});
    chk("starts", 8'(n_exp), 8'(n_st));
    chk("stops", 8'(n_exp), 8'(n_sp));
    chk("takes", 8'h03, 8'(n_tk));
    @(posedge clk);
    #1 en = 0;
    repeat (4) @(posedge clk);
    chk("oe_off", 8'h00, {6'h0, sda_oe, scl_oe});
    $display("test 4 done");
    stop_test;
  end
endmodule // i2c_bus_byte_framing_tb

// file: sim/ssm_i2c_master_model.sv
// Behavioural bus master for the slave bench
// Pulls lines low only; bench models pull-ups
`timescale 1ns/1ns
module ssm_i2c_master_model
(
  input wire scl,
  input wire sda,
  output reg scl_oe_m,
  output reg sda_oe_m
);
  int lo_ns = 120;
  initial
  begin
    scl_oe_m = 0;
    sda_oe_m = 0;
  end
  task start;
    sda_oe_m = 1;
    #62;
    scl_oe_m = 1;
  endtask
  task stop;
    #20;
    sda_oe_m = 1;
    #(lo_ns);
    scl_oe_m = 0;
    #62;
    sda_oe_m = 0;
    #300;
  endtask
  task bit_io(input logic b, output logic r);
    #20;
    sda_oe_m = !b;
    #(lo_ns - 20);
    scl_oe_m = 0;
    wait (scl === 1'b1);
    r = sda;
    #62;
    scl_oe_m = 1;
  endtask
  task xfer(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ak, a);
  endtask
endmodule // ssm_i2c_master_model

// file: sim/ssm_i2c_props.sv
// Checker for the two-wire slave framing engine
// Bound to ssm_i2c_slave; sees its ports only
`timescale 1ns/1ns
module ssm_i2c_props
(
  input wire clk,
  input wire sys_rst,
  input wire serial_port_enable_bit,
  input wire data_hold_long_select,
  input wire scl_i,
  input wire scl_o,
  input wire scl_oe,
  input wire sda_o,
  input wire sda_oe,
  input wire stretch_req,
  input wire tx_take_q,
  input wire rx_valid_q,
  input wire addr_match_q,
  input wire read_req_q,
  input wire bus_idle_q,
  input wire start_seen_q,
  input wire stop_seen_q,
  input wire collision_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_PIN_ZERO: assert property (!scl_o && !sda_o)
    else $error("pin output value not zero");
  AST_OFF_DISABLED: assert property ((!serial_port_enable_bit)[*3] |-> !sda_oe && !scl_oe)
    else $error("pin pulled while disabled");
  AST_DATA_CLK_LOW: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data changed with clock high");
  AST_HOLD_SHORT: assert property ($fell(scl_i) |-> $stable(sda_oe)[*3])
    else $error("data hold too short");
  AST_HOLD_LONG: assert property (data_hold_long_select && $fell(scl_i) |->
    $stable(sda_oe)[*8] ##1 $stable(sda_oe)[*8] ##1 $stable(sda_oe)[*8])
    else $error("long data hold broken");
  AST_STRETCH_ONLY: assert property ($rose(scl_oe) |-> $past(stretch_req) && !scl_i)
    else $error("clock pulled without stretch");
  AST_RX_WRITE: assert property (rx_valid_q |-> addr_match_q && !read_req_q)
    else $error("byte received outside write");
  AST_TX_READ: assert property (tx_take_q |-> addr_match_q && read_req_q)
    else $error("byte sent outside read");
  AST_COLL_HIGH: assert property (collision_q |-> $past(!sda_oe))
    else $error("collision while pulling low");
  AST_IDLE_LOW: assert property ((!scl_i)[*8] |-> !bus_idle_q)
    else $error("idle with clock low");
  AST_MATCH_CLR: assert property (start_seen_q || stop_seen_q |=> !addr_match_q)
    else $error("match kept over condition");
endmodule // ssm_i2c_props
bind ssm_i2c_slave ssm_i2c_props chk_i(.clk, .sys_rst, .serial_port_enable_bit,
  .data_hold_long_select, .scl_i, .scl_o, .scl_oe, .sda_o, .sda_oe, .stretch_req,
  .tx_take_q, .rx_valid_q, .addr_match_q, .read_req_q, .bus_idle_q, .start_seen_q,
  .stop_seen_q, .collision_q);
